// [src/psc_core.sv]
// Protection stage core: group select, state, timers, forcing and counters
`timescale 1ns/1ps
`include "psc_regs.svh"
module psc_core import psc_pkg::*; #(
  parameter int TICK_CYCLES = `PSC_TICK_CYCLES,
  parameter int FLAG_MS     = `PSC_FLAG_MS,
  parameter int FORCE_MS    = `PSC_FORCE_MS,
  parameter int RESET_MS    = `PSC_RESET_MS,
  parameter int DW          = 20,
  parameter int CW          = 16
) (
  // Clock and reset
  input  wire logic            mclk,
  input  wire logic            rstn,
  // Configuration
  input  wire psc_cfg_t        cfg,
  input  wire logic [3:0]      group_input_assign,
  input  wire logic [4*DW-1:0] op_delay_ms,
  input  wire logic [15:0]     level_ratio,
  // Field inputs
  input  wire logic            digital_input_1,
  input  wire logic            digital_input_2,
  input  wire logic            digital_input_3,
  input  wire logic            digital_input_4,
  input  wire logic            pushbutton,
  // Comparators and blocking
  input  wire logic            above_start,
  input  wire logic            above_release,
  input  wire logic            block,
  // Test forcing
  input  wire logic            force_flag_set,
  input  wire logic            force_start_req,
  input  wire logic            force_trip_req,
  // Outputs
  output psc_out_t             stage_out,
  output psc_state_t           stage_state,
  output logic [1:0]           active_group,
  output logic                 force_flag,
  output logic                 output_force_en,
  output logic                 setting_error,
  output logic [CW-1:0]        start_count,
  output logic [CW-1:0]        trip_count
);

  // ---------------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------------
  // Push-button is a front-panel pin, so it is filtered like the others
  localparam int NS = 8;
  logic [NS-1:0] s1_q, s2_q, s3_q, in_q;
  logic [NS-1:0] raw;
  assign raw = {pushbutton, block, above_release, above_start,
                digital_input_4, digital_input_3, digital_input_2, digital_input_1};
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else begin
      s1_q <= raw[NS-1:0];
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NS; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end
  logic [3:0] di;
  logic       pb, blk, f_rel, f_start;
  assign di      = in_q[3:0];
  assign f_start = in_q[4];
  assign f_rel   = in_q[5];
  assign blk     = in_q[6];
  assign pb      = in_q[7];

  // ---------------------------------------------------------------------
  // Millisecond tick
  // ---------------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic        tick_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b0;
    end else if (tick_cnt_q == 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= '0;
      tick_q     <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Setting group selection
  // ---------------------------------------------------------------------
  logic [3:0] grp_act;
  logic [1:0] grp_d, grp_q, prio_grp;
  logic       local_ctl;
  assign grp_act   = di & group_input_assign;
  assign local_ctl = |group_input_assign;
  always_comb begin
    prio_grp = 2'h0;
    if (cfg.group_priority_order) begin
      for (int i = 0; i < 4; i++) begin
        if (grp_act[i]) prio_grp = 2'(i);
      end
    end else begin
      for (int i = 3; i >= 0; i--) begin
        if (grp_act[i]) prio_grp = 2'(i);
      end
    end
  end
  always_comb begin
    if (!local_ctl && cfg.override_en) begin
      grp_d = cfg.global_group_override;
    end else if (|grp_act) begin
      grp_d = prio_grp;
    end else if (cfg.hold_last) begin
      grp_d = grp_q;
    end else begin
      grp_d = cfg.idle_group_select;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      grp_q <= 2'h0;
    end else begin
      grp_q <= grp_d;
    end
  end

  // ---------------------------------------------------------------------
  // Fault with hysteresis
  // ---------------------------------------------------------------------
  logic fault_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fault_q <= 1'b0;
    end else if (f_start) begin
      fault_q <= 1'b1;
    end else if (!f_rel) begin
      fault_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------
  // Operate delay
  // ---------------------------------------------------------------------
  logic [DW-1:0] dly;
  logic          zero_bad;
  logic [31:0]   acc_q, target;
  assign dly      = op_delay_ms[grp_q*DW +: DW];
  assign zero_bad = (dly == '0) && !cfg.accept_zero_delay && !cfg.dependent_mode;
  // Dependent target scales delay by start/measured ratio
  assign target = cfg.dependent_mode ?
                  32'((64'(dly) * 64'(level_ratio)) >> `PSC_DEP_FRAC) : 32'(dly);
  logic op_done;
  assign op_done = (acc_q >= target) && !zero_bad;

  psc_state_t st_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acc_q <= '0;
    end else if (!fault_q) begin
      acc_q <= '0;
    end else if (cfg.dependent_mode && !f_start) begin
      // Dependent accumulation restarts below the start level
      acc_q <= '0;
    end else if (tick_q && !blk && st_q == PSC_START) begin
      acc_q <= acc_q + 32'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Forcing flag and forced status
  // ---------------------------------------------------------------------
  logic [31:0] flag_cnt_q;
  logic [15:0] frc_cnt_q;
  logic        flag_q, frc_s_q, frc_t_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      flag_q     <= 1'b0;
      flag_cnt_q <= '0;
    end else if (force_flag_set) begin
      flag_q     <= 1'b1;
      flag_cnt_q <= '0;
    end else if (flag_q && pb) begin
      flag_cnt_q <= '0;
    end else if (flag_q && tick_q) begin
      if (flag_cnt_q == 32'(FLAG_MS - 1)) begin
        flag_q <= 1'b0;
      end
      flag_cnt_q <= flag_cnt_q + 32'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      frc_s_q   <= 1'b0;
      frc_t_q   <= 1'b0;
      frc_cnt_q <= '0;
    end else if (flag_q && (force_start_req || force_trip_req)) begin
      frc_s_q   <= 1'b1;
      frc_t_q   <= force_trip_req;
      frc_cnt_q <= '0;
    end else if (!flag_q) begin
      frc_s_q <= 1'b0;
      frc_t_q <= 1'b0;
    end else if (tick_q && frc_s_q) begin
      if (frc_cnt_q == 16'(FORCE_MS - 1)) begin
        frc_s_q <= 1'b0;
        frc_t_q <= 1'b0;
      end
      frc_cnt_q <= frc_cnt_q + 16'h1;
    end
  end

  // ---------------------------------------------------------------------
  // Stage state machine
  // ---------------------------------------------------------------------
  psc_state_t st_d;
  always_comb begin
    st_d = st_q;
    case (st_q)
      PSC_IDLE: begin
        if (fault_q && blk) st_d = PSC_BLOCKED;
        else if (fault_q) st_d = PSC_START;
      end
      PSC_START: begin
        if (!fault_q) st_d = PSC_IDLE;
        else if (blk) st_d = PSC_BLOCKED;
        else if (op_done) st_d = PSC_TRIP;
      end
      PSC_BLOCKED: begin
        if (!fault_q) st_d = PSC_IDLE;
        else if (!blk) st_d = PSC_START;
      end
      PSC_TRIP: begin
        if (!fault_q) st_d = PSC_IDLE;
      end
      default: st_d = PSC_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q <= PSC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------------
  // Reset delay and outputs
  // ---------------------------------------------------------------------
  logic [15:0] rel_cnt_q;
  logic        hs_q, ht_q;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      hs_q      <= 1'b0;
      ht_q      <= 1'b0;
      rel_cnt_q <= '0;
    end else if (st_q == PSC_START || st_q == PSC_TRIP) begin
      hs_q      <= 1'b1;
      ht_q      <= ht_q | (st_q == PSC_TRIP);
      rel_cnt_q <= '0;
    end else if ((hs_q || ht_q) && !cfg.latch_en && tick_q) begin
      if (rel_cnt_q == 16'(RESET_MS - 1)) begin
        hs_q <= 1'b0;
        ht_q <= 1'b0;
      end
      rel_cnt_q <= rel_cnt_q + 16'h1;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stage_out       <= '0;
      stage_state     <= PSC_IDLE;
      active_group    <= 2'h0;
      force_flag      <= 1'b0;
      output_force_en <= 1'b0;
      setting_error   <= 1'b0;
    end else begin
      stage_out.start <= hs_q | frc_s_q;
      stage_out.trip  <= ht_q | frc_t_q;
      stage_state     <= frc_t_q ? PSC_TRIP : (frc_s_q ? PSC_START : st_q);
      active_group    <= grp_q;
      force_flag      <= flag_q;
      output_force_en <= flag_q;
      setting_error   <= zero_bad;
    end
  end

  // ---------------------------------------------------------------------
  // Start and trip counters
  // ---------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      start_count <= '0;
      trip_count  <= '0;
    end else begin
      if (st_q != PSC_START && st_d == PSC_START && st_q != PSC_BLOCKED) begin
        start_count <= start_count + 1'b1;
      end
      if (st_q != PSC_TRIP && st_d == PSC_TRIP) begin
        trip_count <= trip_count + 1'b1;
      end
    end
  end
  // One instance per stage; up to the enabled-stage limit in a system
endmodule

// [src/psc_pkg.sv]
// Types shared by the protection stage core
package psc_pkg;
  typedef enum logic [1:0] {
    PSC_IDLE    = 2'b00,
    PSC_START   = 2'b01,
    PSC_TRIP    = 2'b11,
    PSC_BLOCKED = 2'b10
  } psc_state_t;

  typedef struct packed {
    logic [1:0] idle_group_select;
    logic       hold_last;
    logic       group_priority_order;
    logic       override_en;
    logic [1:0] global_group_override;
    logic       dependent_mode;
    logic       accept_zero_delay;
    logic       latch_en;
  } psc_cfg_t;

  typedef struct packed {
    logic start;
    logic trip;
  } psc_out_t;
endpackage

// [src/psc_regs.svh]
// Constants, timing counts and behaviour summary for the protection stage core
// Behaviour
// - At most about thirty stages enabled together; limit depends on load and type.
// - Four setting groups per stage, exactly one active at a time.
// - No group control input active selects the idle group setting.
// - A group input becoming active makes its group the active one.
// - With hold-last set, lost control keeps the last active group.
// - Several inputs active: ascending order lowest wins, descending order highest wins.
// - Global override forces a group only where no local control is configured.
// - Stage reports exactly one of idle, blocked, start, trip.
// - Start and trip counters count each event and clear on reboot; a start entered from blocked is not counted.
// - Forcing flag allows forcing start or trip for half a second.
// - Forcing flag clears five minutes after last push-button activity.
// - Forcing flag also permits forcing digital and analogue outputs.
// - Start at fault detect; trip only when operate delay expires with fault.
// - Fault holds until measured value drops below threshold minus hysteresis.
// - A blocked stage never trips.
// - Blocking freezes delay timer; resumes on unblock, abandoned if fault clears.
// - Blocking after trip does not affect the trip output.
// - Dependent mode: larger quantity trips sooner; accumulation restarts below start.
// - Definite mode: timer runs from activation, trips at delay, resets if deactivated.
// - Zero definite delay rejected unless zero-delay permission is set.
// - Fault clearing noticed within less than fifty milliseconds.
// - Outputs release after reset delay unless latched; delay under 95 ms.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_CLK_MHZ        250
`define PSC_TICK_CYCLES    (`PSC_CLK_MHZ * 1000)
`define PSC_FORCE_MS       500
`define PSC_FLAG_TIMEOUT_S 300
`define PSC_FLAG_MS        (`PSC_FLAG_TIMEOUT_S * 1000)
`define PSC_RESET_MS       90
`define PSC_MAX_STAGES     30
`define PSC_DEP_SCALE      16'h0100
`define PSC_DEP_FRAC       8
`endif

// [testbench/psc_core_props.sv]
// Concurrent checks on the protection stage core ports
`timescale 1ns/1ps
module psc_core_props import psc_pkg::*; #(
  parameter int TICK_CYCLES = 4,
  parameter int FLAG_MS     = 10,
  parameter int CW          = 16
) (
  // Clock and reset
  input wire logic          mclk,
  input wire logic          rstn,
  // Inputs watched
  input wire psc_cfg_t      cfg,
  input wire logic          pushbutton,
  input wire logic          force_flag_set,
  // Outputs watched
  input wire psc_out_t      stage_out,
  input wire psc_state_t    stage_state,
  input wire logic          force_flag,
  input wire logic          output_force_en,
  input wire logic          setting_error,
  input wire logic [CW-1:0] start_count,
  input wire logic [CW-1:0] trip_count
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  localparam int LIM = (FLAG_MS + 2) * TICK_CYCLES + 8;
  logic [31:0] quiet_q;
  // Cycles since the last push-button or flag set
  always_ff @(posedge mclk) begin
    if (!rstn || pushbutton || force_flag_set) quiet_q <= 32'h0;
    else if (quiet_q != 32'hFFFFFFFF) quiet_q <= quiet_q + 32'h1;
  end
  chk_reset_clear: assert property ($rose(rstn) |-> stage_state == PSC_IDLE
    && stage_out == 2'h0 && start_count == '0 && trip_count == '0) else $error("reset state");
  chk_force_mirror: assert property (output_force_en == force_flag)
    else $error("force enable differs from flag");
  chk_start_step: assert property ($changed(start_count)
    |-> start_count == $past(start_count) + 1'b1) else $error("start count step");
  chk_trip_step: assert property ($changed(trip_count)
    |-> trip_count == $past(trip_count) + 1'b1) else $error("trip count step");
  chk_blocked_no_trip: assert property (stage_state == PSC_BLOCKED && !force_flag
    |-> !$rose(stage_out.trip)) else $error("trip while blocked");
  chk_zero_refused: assert property (setting_error && !force_flag
    |-> !$rose(stage_out.trip)) else $error("trip with refused delay");
  chk_trip_with_start: assert property ($rose(stage_out.trip) && !force_flag
    |-> stage_out.start) else $error("trip without start");
  chk_latch_hold: assert property (cfg.latch_en && stage_out.trip
    |=> stage_out.trip) else $error("latched trip dropped");
  chk_flag_timeout: assert property (quiet_q > LIM |-> !force_flag)
    else $error("force flag outlived timeout");
  cover property ($rose(stage_out.trip));
  cover property (stage_state == PSC_BLOCKED);
  cover property ($fell(force_flag));
endmodule

bind psc_core psc_core_props #(.TICK_CYCLES(TICK_CYCLES), .FLAG_MS(FLAG_MS), .CW(CW)) i_props (
  .mclk(mclk), .rstn(rstn), .cfg(cfg), .pushbutton(pushbutton),
  .force_flag_set(force_flag_set), .stage_out(stage_out), .stage_state(stage_state),
  .force_flag(force_flag), .output_force_en(output_force_en),
  .setting_error(setting_error), .start_count(start_count), .trip_count(trip_count));

// [testbench/psc_core_tb.sv]
// Self-checking testbench for the protection stage core
`timescale 1ns/1ps
module psc_core_tb import psc_pkg::*;;
  logic        mclk, rstn, pb, fset, fsreq, ftreq, blk_req, a_st, a_rel, blk;
  logic [3:0]  gia, di;
  logic [79:0] dly;
  logic [7:0]  lvl, slv, hyv;
  logic [15:0] lratio;
  psc_cfg_t    cfg;
  psc_out_t    so;
  psc_state_t  st;
  logic [1:0]  grp;
  logic        ff, ofe, serr;
  logic [15:0] sc, tc;
  int          n_fail, n_tests, cycles;

  psc_core #(.TICK_CYCLES(4), .FLAG_MS(10), .FORCE_MS(5), .RESET_MS(3)) i_dut (
    .mclk(mclk), .rstn(rstn), .cfg(cfg), .group_input_assign(gia), .op_delay_ms(dly),
    .level_ratio(lratio), .digital_input_1(di[0]), .digital_input_2(di[1]),
    .digital_input_3(di[2]), .digital_input_4(di[3]), .pushbutton(pb),
    .above_start(a_st), .above_release(a_rel), .block(blk), .force_flag_set(fset),
    .force_start_req(fsreq), .force_trip_req(ftreq), .stage_out(so), .stage_state(st),
    .active_group(grp), .force_flag(ff), .output_force_en(ofe), .setting_error(serr),
    .start_count(sc), .trip_count(tc));
  psc_meas_model i_meas (.level(lvl), .start_lv(slv), .hyst(hyv), .blk_req(blk_req),
    .above_start(a_st), .above_release(a_rel), .block(blk));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task report_and_stop;
    $display("counts: tests=%0d fails=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task grp_case(input logic hold, input logic prio, input logic [3:0] d, input logic [1:0] e);
    cfg.hold_last = hold;
    cfg.group_priority_order = prio;
    di = d;
    cyc(10);
    chk(grp, e);
  endtask
  task pulse_flag;
    fset = 1'b1;
    cyc(1);
    fset = 0;
    cyc(2);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0; pb = 0; fset = 0; fsreq = 0; ftreq = 0; blk_req = 0;
    lvl = 8'h00; di = 4'h0; gia = 4'hF; dly = {4{20'h0000A}};
    lratio = 16'h0100; slv = 8'h40; hyv = 8'h08;
    cfg = '{idle_group_select: 2'h2, global_group_override: 2'h1, default: 1'b0};
    cyc(20);
    rstn = 1'b1;
    cyc(2);
    grp_case(0, 0, 4'h0, 2'h2);
    grp_case(0, 0, 4'h1, 2'h0);
    grp_case(0, 0, 4'h6, 2'h1);
    grp_case(0, 1, 4'h6, 2'h2);
    grp_case(1, 0, 4'h8, 2'h3);
    grp_case(1, 0, 4'h0, 2'h3);
    gia = 4'h0; cfg.override_en = 1;
    grp_case(0, 0, 4'h0, 2'h1);
    gia = 4'hF;
    grp_case(0, 0, 4'h0, 2'h2);
    $display("test groups done");
    lvl = 8'h50; cyc(10);
    chk(so.start, 1); chk(st, PSC_START);
    cyc(20); chk(so.trip, 0);
    cyc(30); chk(so.trip, 1); chk(st, PSC_TRIP);
    chk(sc, 1); chk(tc, 1);
    lvl = 8'h3C; cyc(30); chk(so.trip, 1);
    lvl = 8'h20; cyc(4); chk(so.trip, 1);
    cyc(30); chk(so, 2'h0); chk(st, PSC_IDLE);
    $display("test definite done");
    lvl = 8'h50; cyc(30); blk_req = 1; cyc(40);
    chk(st, PSC_BLOCKED); chk(so.trip, 0);
    blk_req = 0; cyc(8); chk(so.trip, 0);
    cyc(24); chk(so.trip, 1);
    blk_req = 1; cyc(10); chk(so.trip, 1); chk(tc, 2);
    blk_req = 0; lvl = 8'h00; cyc(40);
    $display("test blocking done");
    cfg.dependent_mode = 1; lratio = 16'h0080; lvl = 8'h50;
    cyc(16); chk(so.trip, 0);
    cyc(24); chk(so.trip, 1);
    lvl = 8'h00; cfg.dependent_mode = 0; lratio = 16'h0100; cyc(40);
    $display("test dependent done");
    dly = '0; lvl = 8'h50; cyc(60);
    chk(serr, 1); chk(so.trip, 0);
    cfg.accept_zero_delay = 1; cfg.latch_en = 1; cyc(10); chk(so.trip, 1);
    lvl = 8'h00; cyc(40); chk(so.trip, 1);
    rstn = 1'b0; cyc(3); rstn = 1'b1; cyc(2);
    chk(tc, 0); chk(so, 2'h0);
    cfg.accept_zero_delay = 0; cfg.latch_en = 0; dly = {4{20'h0000A}};
    $display("test zero delay done");
    pulse_flag(); chk(ff, 1); chk(ofe, 1);
    fsreq = 1; cyc(1); fsreq = 0; cyc(4); chk(so.start, 1);
    cyc(60); chk(so.start, 0); chk(ff, 0);
    pulse_flag(); ftreq = 1; cyc(1); ftreq = 0; cyc(4); chk(so.trip, 1);
    cyc(20); pb = 1; cyc(4); pb = 0;
    cyc(30); chk(ff, 1);
    cyc(30); chk(ff, 0);
    $display("test forcing done");
    report_and_stop();
  end
endmodule

// [testbench/psc_meas_model.sv]
// Comparator and blocking model facing the protection stage core
`timescale 1ns/1ps
module psc_meas_model (
  // Measured level and thresholds
  input  wire logic [7:0] level,
  input  wire logic [7:0] start_lv,
  input  wire logic [7:0] hyst,
  // Blocking request
  input  wire logic       blk_req,
  // Comparator outputs
  output logic            above_start,
  output logic            above_release,
  output logic            block
);
  // Release comparator sits one hysteresis step below the start level
  assign above_start   = (level >= start_lv);
  assign above_release = (level >= (start_lv - hyst));
  assign block         = blk_req;
endmodule
